// ===== core/supervisor_timer.sv
// watchdog timer and on-button supervisor with apb registers and interrupt
//
// Summary of operation
// - first expiry of the selected period (0.256s doubling to 32.768s) takes primary action
// - a second unkicked period in a row takes the secondary action
// - action codes: none, interrupt, device reset, wake transition
// - writing the kick bit restarts the timer only with software source selected
// - in sleep the timer stops unless sleep-run enable is set
// - protected fields change only while the key is unlocked
// - button press takes primary action: ignore, on request, off request
// - every button press raises an interrupt
// - button held one hold period takes hold action: interrupt, on, off
// - hold period code selects 1s, 2s, 4s or 8s
// - a read-only bit shows the present button pin level
// - timer runs only while enabled; enabling does not restart the count
// - pause holds the count without clearing it
`timescale 1ns/1ns
module supervisor_timer import supervisor_pkg::*; #(
    parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_state,
    input wire logic hw_kick,
    input wire logic button_pin,
    output logic irq,
    output logic device_reset_req,
    output logic wake_req,
    output logic on_req,
    output logic off_req
);
    if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 32'h00ff_ffff) begin : g_bad_tick
        $error("TICK_CYCLES_P out of range");
    end

    function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
        return a == {14'h0000, idx, 2'b00};
    endfunction : hit

    function automatic logic [15:0] scaled_ms(input logic [15:0] base, input logic [2:0] code);
        return base << code;
    endfunction : scaled_ms

    // bus decode
    logic setup, wr;
    logic sel_wd, sel_btn, sel_key, sel_sts, sel_clr, sel_en, mapped;
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign sel_wd = hit(paddr, WDOG_CTRL_IDX);
    assign sel_btn = hit(paddr, BTN_CTRL_IDX);
    assign sel_key = hit(paddr, KEY_IDX);
    assign sel_sts = hit(paddr, IRQ_STATUS_IDX);
    assign sel_clr = hit(paddr, IRQ_CLEAR_IDX);
    assign sel_en = hit(paddr, IRQ_ENABLE_IDX);
    assign mapped = sel_wd | sel_btn | sel_key | sel_sts | sel_clr | sel_en;
    // read data is latched in setup, so the access phase never needs a wait state
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // register group
    wdog_cfg_t wd_cfg_q, wd_cfg_d;
    button_cfg_t btn_cfg_q, btn_cfg_d;
    logic [15:0] key_q, key_d;
    logic [IRQ_W-1:0] en_q, en_d, sts_q, sts_d, events;
    logic [31:0] prdata_d;
    logic unlocked, sw_kick;
    assign unlocked = key_q == KEY_UNLOCK;
    assign sw_kick = wr & sel_wd & pwdata[WD_KICK_BIT];

    always_comb begin
        wd_cfg_d = wd_cfg_q;
        btn_cfg_d = btn_cfg_q;
        key_d = key_q;
        en_d = en_q;
        prdata_d = prdata;
        if (wr && sel_key) begin
            key_d = pwdata[15:0];
        end
        if (wr && unlocked && sel_wd) begin
            wd_cfg_d.enable = pwdata[WD_ENA_BIT];
            wd_cfg_d.pause = pwdata[WD_PAUSE_BIT];
            wd_cfg_d.src = pwdata[WD_SRC_BIT];
            wd_cfg_d.sleep_run = pwdata[WD_SLP_BIT];
            wd_cfg_d.second = pwdata[WD_SEC_LSB +: 2];
            wd_cfg_d.first = pwdata[WD_PRIM_LSB +: 2];
            wd_cfg_d.period = pwdata[WD_TO_LSB +: 3];
        end
        if (wr && unlocked && sel_btn) begin
            btn_cfg_d.hold_action = pwdata[BTN_HOLD_LSB +: 2];
            btn_cfg_d.press_action = pwdata[BTN_PRESS_LSB +: 2];
            btn_cfg_d.hold_period = pwdata[BTN_TO_LSB +: 2];
        end
        if (wr && sel_en) begin
            en_d = pwdata[IRQ_W-1:0];
        end
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (sel_wd) begin
                // kick bit always reads back zero
                prdata_d[15:0] = {wd_cfg_q.enable, wd_cfg_q.pause, wd_cfg_q.src,
                    wd_cfg_q.sleep_run, 2'b00, wd_cfg_q.second, 2'b00, wd_cfg_q.first,
                    1'b0, wd_cfg_q.period};
            end else if (sel_btn) begin
                prdata_d[15:0] = {6'h00, btn_cfg_q.hold_action, 2'b00,
                    btn_cfg_q.press_action, button_pin, 1'b0, btn_cfg_q.hold_period};
            end else if (sel_key) begin
                prdata_d[0] = unlocked;
            end else if (sel_sts) begin
                prdata_d[IRQ_W-1:0] = sts_q;
            end else if (sel_en) begin
                prdata_d[IRQ_W-1:0] = en_q;
            end
        end
        // set wins over a clear in the same cycle
        sts_d = (sts_q & ~((wr && sel_clr) ? pwdata[IRQ_W-1:0] : '0)) | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cfg_q <= wdog_cfg_t'({WDOG_CTRL_RST[15:12], WDOG_CTRL_RST[9:8],
                WDOG_CTRL_RST[5:4], WDOG_CTRL_RST[2:0]});
            btn_cfg_q <= button_cfg_t'({BTN_CTRL_RST[9:8], BTN_CTRL_RST[5:4],
                BTN_CTRL_RST[1:0]});
            key_q <= 16'h0000;
            en_q <= '0;
            sts_q <= '0;
            prdata <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            wd_cfg_q <= wd_cfg_d;
            btn_cfg_q <= btn_cfg_d;
            key_q <= key_d;
            en_q <= en_d;
            sts_q <= sts_d;
            prdata <= prdata_d;
            irq <= |(sts_d & en_d);
        end
    end

    // millisecond timebase
    logic [23:0] tick_cnt_q, tick_cnt_d;
    logic tick;
    assign tick = tick_cnt_q == 24'(TICK_CYCLES_P - 1);

    always_comb begin
        tick_cnt_d = tick ? 24'h00_0000 : tick_cnt_q + 24'h00_0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 24'h00_0000;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // watchdog group
    logic [15:0] wd_cnt_q, wd_cnt_d, wd_ms;
    wd_phase_t wd_phase_q, wd_phase_d;
    logic wd_run, kick_ok, wd_first, wd_second;
    logic [1:0] wd_act;
    assign wd_ms = scaled_ms(WDOG_BASE_MS, wd_cfg_q.period);
    assign wd_run = wd_cfg_q.enable & ~wd_cfg_q.pause
        & (~sleep_state | wd_cfg_q.sleep_run);
    assign kick_ok = wd_cfg_q.src ? sw_kick : hw_kick;

    always_comb begin
        wd_cnt_d = wd_cnt_q;
        wd_phase_d = wd_phase_q;
        wd_first = 1'b0;
        wd_second = 1'b0;
        if (kick_ok) begin
            wd_cnt_d = 16'h0000;
            wd_phase_d = WD_FIRST;
        end else if (tick && wd_run) begin
            // >= so that shortening the period mid-count still expires
            if (wd_cnt_q + 16'h0001 >= wd_ms) begin
                wd_cnt_d = 16'h0000;
                case (wd_phase_q)
                    WD_FIRST: begin
                        wd_first = 1'b1;
                        wd_phase_d = WD_SECOND;
                    end
                    WD_SECOND: begin
                        wd_second = 1'b1;
                        wd_phase_d = WD_FIRST;
                    end
                    default: begin
                        wd_phase_d = WD_FIRST;
                    end
                endcase
            end else begin
                wd_cnt_d = wd_cnt_q + 16'h0001;
            end
        end
        wd_act = wd_first ? wd_cfg_q.first : (wd_second ? wd_cfg_q.second : ACT_NONE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_q <= 16'h0000;
            wd_phase_q <= WD_FIRST;
            device_reset_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
            wd_phase_q <= wd_phase_d;
            device_reset_req <= wd_act == ACT_RESET;
            wake_req <= wd_act == ACT_WAKE;
        end
    end

    // on-button group; pin low means pressed
    logic [15:0] btn_cnt_q, btn_cnt_d, btn_ms;
    logic btn_prev_q, btn_done_q, btn_done_d, pressed, press_evt, hold_evt;
    assign pressed = ~button_pin;
    assign press_evt = pressed & ~btn_prev_q;
    assign btn_ms = scaled_ms(BTN_BASE_MS, {1'b0, btn_cfg_q.hold_period});

    always_comb begin
        btn_cnt_d = btn_cnt_q;
        btn_done_d = btn_done_q;
        hold_evt = 1'b0;
        if (!pressed) begin
            btn_cnt_d = 16'h0000;
            btn_done_d = 1'b0;
        end else if (tick && !btn_done_q) begin
            if (btn_cnt_q + 16'h0001 >= btn_ms) begin
                hold_evt = 1'b1;
                btn_done_d = 1'b1;
            end else begin
                btn_cnt_d = btn_cnt_q + 16'h0001;
            end
        end
        events = '0;
        events[IRQ_WDOG] = wd_act == ACT_IRQ;
        events[IRQ_PRESS] = press_evt;
        events[IRQ_HOLD] = hold_evt && btn_cfg_q.hold_action == BTN_HOLD_IRQ;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_cnt_q <= 16'h0000;
            btn_done_q <= 1'b0;
            btn_prev_q <= 1'b0;
            on_req <= 1'b0;
            off_req <= 1'b0;
        end else begin
            btn_cnt_q <= btn_cnt_d;
            btn_done_q <= btn_done_d;
            btn_prev_q <= pressed;
            on_req <= (press_evt && btn_cfg_q.press_action == BTN_ON)
                || (hold_evt && btn_cfg_q.hold_action == BTN_ON);
            off_req <= (press_evt && btn_cfg_q.press_action == BTN_OFF)
                || (hold_evt && btn_cfg_q.hold_action == BTN_OFF);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    kick_restart_a: assert property ((sw_kick && wd_cfg_q.src)
        |=> wd_cnt_q == 16'h0000 && wd_phase_q == WD_FIRST)
        else $error("software kick did not restart");
    hw_kick_blocked_a: assert property ((hw_kick && wd_cfg_q.src && !sw_kick && !tick)
        |=> $stable(wd_cnt_q)) else $error("hardware kick accepted");
    first_reset_a: assert property ((wd_first && wd_cfg_q.first == ACT_RESET)
        |=> device_reset_req) else $error("primary reset missing");
    expiry_count_a: assert property ((tick && wd_run && !kick_ok
        && wd_cnt_q + 16'h0001 < wd_ms) |-> !wd_first && !wd_second)
        else $error("early expiry");
    second_after_first_a: assert property (wd_second
        |-> wd_phase_q == WD_SECOND && $past(wd_phase_q) == WD_SECOND)
        else $error("secondary out of order");
    wake_action_a: assert property ((wd_act == ACT_WAKE)
        |=> wake_req && !device_reset_req) else $error("wake decode wrong");
    sleep_gate_a: assert property ((sleep_state && !wd_cfg_q.sleep_run && !kick_ok)
        |=> $stable(wd_cnt_q)) else $error("watchdog ran in sleep");
    pause_hold_a: assert property ((wd_cfg_q.pause && !kick_ok)
        |=> $stable(wd_cnt_q) && $stable(wd_phase_q)) else $error("paused count moved");
    key_lock_a: assert property ((wr && !unlocked)
        |=> $stable(wd_cfg_q) && $stable(btn_cfg_q)) else $error("locked field changed");
    press_action_a: assert property ((press_evt
        && btn_cfg_q.press_action == BTN_OFF) |=> off_req && sts_q[IRQ_PRESS])
        else $error("press action missing");
    hold_action_a: assert property ((hold_evt && btn_cfg_q.hold_action == BTN_ON)
        |=> on_req ##1 !on_req) else $error("hold action missing");
    hold_period_a: assert property (hold_evt
        |-> btn_cnt_q + 16'h0001 >= btn_ms && tick) else $error("hold fired early");
    release_clear_a: assert property (button_pin
        |=> btn_cnt_q == 16'h0000 && !btn_done_q) else $error("hold timer not cleared");
    level_read_a: assert property ((setup && sel_btn)
        |=> prdata[BTN_LEVEL_BIT] == $past(button_pin)) else $error("pin level misread");
endmodule : supervisor_timer

// ===== core/supervisor_pkg.sv
// constants, field layout and types for the watchdog and on-button supervisor
package supervisor_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_TIME_US = 1000;
    localparam int unsigned TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] WDOG_BASE_MS = 16'h0100;
    localparam logic [15:0] BTN_BASE_MS = 16'h03e8;
    localparam logic [15:0] WDOG_CTRL_IDX = 16'h4004;
    localparam logic [15:0] BTN_CTRL_IDX = 16'h4005;
    localparam logic [15:0] KEY_IDX = 16'h4008;
    localparam logic [15:0] IRQ_STATUS_IDX = 16'h4010;
    localparam logic [15:0] IRQ_CLEAR_IDX = 16'h4011;
    localparam logic [15:0] IRQ_ENABLE_IDX = 16'h4012;
    localparam logic [15:0] KEY_UNLOCK = 16'h9716;
    localparam logic [15:0] WDOG_CTRL_RST = 16'ha217;
    localparam logic [15:0] BTN_CTRL_RST = 16'h0100;
    localparam int unsigned WD_ENA_BIT = 15;
    localparam int unsigned WD_PAUSE_BIT = 14;
    localparam int unsigned WD_SRC_BIT = 13;
    localparam int unsigned WD_SLP_BIT = 12;
    localparam int unsigned WD_KICK_BIT = 11;
    localparam int unsigned WD_SEC_LSB = 8;
    localparam int unsigned WD_PRIM_LSB = 4;
    localparam int unsigned WD_TO_LSB = 0;
    localparam int unsigned BTN_HOLD_LSB = 8;
    localparam int unsigned BTN_PRESS_LSB = 4;
    localparam int unsigned BTN_LEVEL_BIT = 3;
    localparam int unsigned BTN_TO_LSB = 0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_IRQ = 2'h1;
    localparam logic [1:0] ACT_RESET = 2'h2;
    localparam logic [1:0] ACT_WAKE = 2'h3;
    localparam logic [1:0] BTN_HOLD_IRQ = 2'h0;
    localparam logic [1:0] BTN_ON = 2'h1;
    localparam logic [1:0] BTN_OFF = 2'h2;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_WDOG = 0;
    localparam int unsigned IRQ_PRESS = 1;
    localparam int unsigned IRQ_HOLD = 2;

    typedef struct packed {
        logic enable;
        logic pause;
        logic src;
        logic sleep_run;
        logic [1:0] second;
        logic [1:0] first;
        logic [2:0] period;
    } wdog_cfg_t;

    typedef struct packed {
        logic [1:0] hold_action;
        logic [1:0] press_action;
        logic [1:0] hold_period;
    } button_cfg_t;

    typedef enum logic [1:0] {
        WD_FIRST = 2'b01,
        WD_SECOND = 2'b10
    } wd_phase_t;
endpackage : supervisor_pkg

// ===== testbench/button_pusher.sv
// on-button partner: pin pulled up, low only while pressed
`timescale 1ns/1ns
module button_pusher (
    input wire logic pclk,
    input wire logic press,
    output logic button_pin
);
    // moves only after an edge, like a synchronised pin; high from the first edge
    always @(posedge pclk) begin
        button_pin <= !press;
    end
endmodule : button_pusher

// ===== testbench/tb_watchdog_and_on_pin_supervisor.sv
// self-checking bench for the supervisor timer
`timescale 1ns/1ns
module tb_watchdog_and_on_pin_supervisor import supervisor_pkg::*; ;
    localparam int unsigned TK = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic sleep_state = 1'b0;
    logic hw_kick = 1'b0;
    logic press = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, device_reset_req, wake_req, on_req, off_req, button_pin, err;
    int fails = 0;
    int checks_done = 0;
    int cnt[4];

    supervisor_timer #(.TICK_CYCLES_P(TK)) i_supervisor_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_state(sleep_state), .hw_kick(hw_kick),
        .button_pin(button_pin), .irq(irq), .device_reset_req(device_reset_req),
        .wake_req(wake_req), .on_req(on_req), .off_req(off_req)
    );
    button_pusher i_button_pusher (.pclk(pclk), .press(press), .button_pin(button_pin));

    initial begin
        forever #5 pclk = !pclk;
    end

    // pulse tallies: 0 reset, 1 wake, 2 on, 3 off
    always @(posedge pclk) begin
        if (device_reset_req === 1'b1) cnt[0]++;
        if (wake_req === 1'b1) cnt[1]++;
        if (on_req === 1'b1) cnt[2]++;
        if (off_req === 1'b1) cnt[3]++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {14'h0000, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: only the watchdog process ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask : rchk

    function automatic logic [31:0] wd(input logic [1:0] p, input logic [1:0] s,
                                      input logic [15:0] x);
        return {22'h00_0000, s, 2'h0, p, 4'h0} | {16'h0000, x};
    endfunction : wd

    task automatic t_regs;
        rchk("watchdog word", WDOG_CTRL_IDX, 32'h0000_a217);
        rchk("button word", BTN_CTRL_IDX, 32'h0000_0108);
        wr(WDOG_CTRL_IDX, 32'h0000_0000);
        rchk("locked write", WDOG_CTRL_IDX, 32'h0000_a217);
        apb(1'b0, 16'h4020, 32'h0000_0000);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
        wr(KEY_IDX, {16'h0000, KEY_UNLOCK});
        wr(IRQ_ENABLE_IDX, 32'h0000_0006);
        $display("test registers done");
    endtask : t_regs

    task automatic t_actions;
        for (int a = 0; a < 4; a++) begin
            wr(WDOG_CTRL_IDX, wd(a[1:0], 2'h0, 16'ha800));
            cnt = '{default: 0};
            cyc(500);
            chk("early action", 32'(cnt[0] + cnt[1]), 32'h0000_0000);
            cyc(40);
            chk("reset pulse", 32'(cnt[0]), 32'(a == 2));
            chk("wake pulse", 32'(cnt[1]), 32'(a == 3));
            apb(1'b0, IRQ_STATUS_IDX, 32'h0000_0000);
            chk("watchdog status", rd & 32'h0000_0001, 32'(a == 1));
            chk("masked irq", {31'h0, irq}, 32'h0000_0000);
            if (a == 1) begin
                wr(IRQ_ENABLE_IDX, 32'h0000_0007);
                cyc(2);
                chk("enabled irq", {31'h0, irq}, 32'h0000_0001);
            end
            wr(IRQ_CLEAR_IDX, 32'h0000_0007);
        end
        cyc(2);
        chk("cleared irq", {31'h0, irq}, 32'h0000_0000);
        $display("test actions done");
    endtask : t_actions

    task automatic t_second;
        wr(WDOG_CTRL_IDX, wd(2'h0, 2'h2, 16'ha800));
        cnt = '{default: 0};
        // hardware kicks must not restart a software-sourced timer
        hw_kick <= 1'b1;
        cyc(1010);
        chk("early second", 32'(cnt[0]), 32'h0000_0000);
        cyc(40);
        chk("second action", 32'(cnt[0]), 32'h0000_0001);
        hw_kick <= 1'b0;
        $display("test second expiry done");
    endtask : t_second

    task automatic t_kick;
        wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'ha800));
        cnt = '{default: 0};
        repeat (3) begin
            cyc(400);
            wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'ha800));
        end
        chk("kicked reset", 32'(cnt[0]), 32'h0000_0000);
        cnt = '{default: 0};
        wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'h8000));
        cyc(300);
        wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'h8800));
        cyc(240);
        chk("ignored kick", 32'(cnt[0]), 32'h0000_0001);
        cnt = '{default: 0};
        // spans past the unkicked primary expiry, so a lost kick shows
        repeat (5) begin
            cyc(300);
            hw_kick <= 1'b1;
            cyc(1);
            hw_kick <= 1'b0;
        end
        chk("hardware kick", 32'(cnt[0]), 32'h0000_0000);
        $display("test kick done");
    endtask : t_kick

    task automatic t_stall;
        for (int m = 0; m < 3; m++) begin
            wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'ha800));
            cnt = '{default: 0};
            cyc(300);
            if (m == 1) sleep_state <= 1'b1;
            else wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, m == 0 ? 16'he000 : 16'h2000));
            cyc(600);
            chk("stalled count", 32'(cnt[0]), 32'h0000_0000);
            sleep_state <= 1'b0;
            wr(WDOG_CTRL_IDX, wd(2'h2, 2'h0, 16'ha000));
            cyc(260);
            chk("resumed count", 32'(cnt[0]), 32'h0000_0001);
        end
        wr(WDOG_CTRL_IDX, 32'h0000_2000);
        $display("test stall done");
    endtask : t_stall

    task automatic t_button;
        for (int p = 0; p < 3; p++) begin
            wr(BTN_CTRL_IDX, {22'h00_0000, 2'h3, 2'h0, p[1:0], 4'h0});
            cnt = '{default: 0};
            press <= 1'b1;
            cyc(4);
            rchk("pressed level", BTN_CTRL_IDX, {22'h00_0000, 2'h3, 2'h0, p[1:0], 4'h0});
            chk("on request", 32'(cnt[2]), 32'(p == 1));
            chk("off request", 32'(cnt[3]), 32'(p == 2));
            chk("press irq", {31'h0, irq}, 32'h0000_0001);
            press <= 1'b0;
            wr(IRQ_CLEAR_IDX, 32'h0000_0007);
        end
        wr(BTN_CTRL_IDX, 32'h0000_0200);
        cnt = '{default: 0};
        press <= 1'b1;
        cyc(1500);
        press <= 1'b0;
        cyc(10);
        press <= 1'b1;
        cyc(1950);
        chk("early hold", 32'(cnt[3]), 32'h0000_0000);
        cyc(100);
        chk("hold action", 32'(cnt[3]), 32'h0000_0001);
        press <= 1'b0;
        for (int h = 0; h < 2; h++) begin
            wr(IRQ_CLEAR_IDX, 32'h0000_0007);
            wr(BTN_CTRL_IDX, h == 0 ? 32'h0000_0100 : 32'h0000_0000);
            cnt = '{default: 0};
            press <= 1'b1;
            cyc(2100);
            chk("hold on request", 32'(cnt[2]), 32'(h == 0));
            apb(1'b0, IRQ_STATUS_IDX, 32'h0000_0000);
            chk("hold status", rd & 32'h0000_0004, h == 0 ? 32'h0000_0000 : 32'h0000_0004);
            press <= 1'b0;
        end
        $display("test button done");
    endtask : t_button

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        cnt = '{default: 0};
        cyc(2);
        presetn <= 1'b1;
        t_regs();
        t_actions();
        t_second();
        t_kick();
        t_stall();
        t_button();
        finish_test();
    end

    initial begin
        #400_000;
        fails++;
        finish_test();
    end
endmodule : tb_watchdog_and_on_pin_supervisor
